// ===== hw/skip_table_cfg.svh
// Purpose: Constants for the skip, table read and XOR execution block
// Assumes: Word-aligned register offsets on a 32-bit Wishbone bus
// Notes:   Offsets are byte addresses
`ifndef SKIP_TABLE_CFG_SVH
`define SKIP_TABLE_CFG_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define OFS_ACCUM        8'h00
`define OFS_TBL_PTR_LOW  8'h04
`define OFS_TBL_PTR_HIGH 8'h08
`define OFS_TBL_HIGH     8'h0c
`define OFS_STATUS       8'h10

// ---------------------------------------------------------------
// Status field positions
// ---------------------------------------------------------------
`define ST_ZERO_BIT      0
`define ST_SKIP_BIT      1
`define ST_BUSY_BIT      2

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RST_BYTE         8'h00
`define RST_ZERO_FLAG    1'b0

`endif

// ===== hw/skip_table_pkg.sv
// Purpose: Types for the skip, table read and XOR execution block
// Assumes: Three-bit operation code from the decode stage
// Notes:   States are one-hot
package skip_table_pkg;

  typedef enum logic [2:0] {
    copy_test_skip_op              = 3'h0,
    test_skip_op                   = 3'h1,
    table_read_current_page_op     = 3'h2,
    table_read_last_page_op        = 3'h3,
    preinc_table_read_op           = 3'h4,
    preinc_table_read_last_page_op = 3'h5,
    xor_to_accumulator_op          = 3'h6,
    xor_to_memory_op               = 3'h7
  } op_code_t;

  typedef enum logic [6:0] {
    st_idle    = 7'h01,
    st_dm_req  = 7'h02,
    st_dm_data = 7'h04,
    st_pm_req  = 7'h08,
    st_pm_data = 7'h10,
    st_write   = 7'h20,
    st_dummy   = 7'h40
  } exec_state_t;

endpackage

// ===== hw/wb_reg_slave.sv
// Purpose: Classic Wishbone slave front end with registered answer
// Assumes: One aligned 32-bit word per register, byte lane 0 carries data
// Notes:   Unmapped addresses answer with zero and ignore writes
`timescale 1ns/100ps
`include "skip_table_cfg.svh"

module wb_reg_slave (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Wishbone slave
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic [7:0] wb_adr_i,
  input  wire logic [3:0] wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic            wb_ack_o,
  // Register file side
  input  wire logic [7:0] rd_accum_i,
  input  wire logic [7:0] rd_ptr_low_i,
  input  wire logic [7:0] rd_ptr_high_i,
  input  wire logic [7:0] rd_tbl_high_i,
  input  wire logic [7:0] rd_status_i,
  output logic            wr_accum_o,
  output logic            wr_ptr_low_o,
  output logic            wr_ptr_high_o,
  output logic            wr_status_o
);

  wire       take_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire       wr_lane   = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
  wire       hit_acc   = (wb_adr_i == `OFS_ACCUM);
  wire       hit_plo   = (wb_adr_i == `OFS_TBL_PTR_LOW);
  wire       hit_phi   = (wb_adr_i == `OFS_TBL_PTR_HIGH);
  wire       hit_tbh   = (wb_adr_i == `OFS_TBL_HIGH);
  wire       hit_sta   = (wb_adr_i == `OFS_STATUS);
  wire [7:0] rd_sel    = hit_acc ? rd_accum_i    :
                         hit_plo ? rd_ptr_low_i  :
                         hit_phi ? rd_ptr_high_i :
                         hit_tbh ? rd_tbl_high_i :
                         hit_sta ? rd_status_i   : 8'h00;

  // Strobes act on the edge where the master samples ack
  assign wr_accum_o    = wr_lane && hit_acc;
  assign wr_ptr_low_o  = wr_lane && hit_plo;
  assign wr_ptr_high_o = wr_lane && hit_phi;
  assign wr_status_o   = wr_lane && hit_sta;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= take_req;
      wb_dat_o <= take_req ? {24'h00_0000, rd_sel} : 32'h0000_0000;
    end
  end

endmodule

// ===== hw/skip_table_read_xor_exec.sv
// Purpose: Executes the skip, table read and XOR group of core instructions
// Assumes: Data and program memories return read data one cycle after the read strobe
// Notes:   Accumulator, zero flag, table pointers and latch live here
`timescale 1ns/100ps
`include "skip_table_cfg.svh"

module skip_table_read_xor_exec
  import skip_table_pkg::*;
#(
  parameter int DM_AW = 9,
  parameter int PM_AW = 16
) (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Decoded instruction from fetch stage
  input  wire logic               op_valid_i,
  input  wire op_code_t           op_code_i,
  input  wire logic [DM_AW-1:0]   op_addr_i,
  input  wire logic [2:0]         op_bit_i,
  input  wire logic [PM_AW-9:0]   cur_page_i,
  output logic                    op_ready_o,
  output logic                    skip_o,
  output logic                    dummy_o,
  // Data memory
  output logic      [DM_AW-1:0]   dm_addr_o,
  output logic                    dm_rd_o,
  output logic                    dm_wr_o,
  output logic      [7:0]         dm_wdata_o,
  input  wire logic [7:0]         dm_rdata_i,
  // Program memory
  output logic      [PM_AW-1:0]   pm_addr_o,
  output logic                    pm_rd_o,
  input  wire logic [15:0]        pm_rdata_i,
  // Core state
  output logic      [7:0]         acc_o,
  output logic                    zero_o,
  output logic      [7:0]         table_high_latch_o,
  // Wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o
);

  if (DM_AW < 1 || DM_AW > 16) begin : g_bad_dm
    $error("DM_AW out of range");
  end
  if (PM_AW < 9 || PM_AW > 16) begin : g_bad_pm
    $error("PM_AW out of range");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  exec_state_t            state_reg;
  exec_state_t            state_next;
  op_code_t               op_reg;
  logic [2:0]             bit_reg;
  logic [7:0]             table_pointer_low;
  logic [PM_AW-9:0]       table_pointer_high;
  logic                   skip_pending_reg;

  logic                   wr_accum;
  logic                   wr_ptr_low;
  logic                   wr_ptr_high;
  logic                   wr_status;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire        accept       = op_valid_i && op_ready_o;
  wire        accept_skip  = accept && skip_pending_reg;
  wire        accept_exec  = accept && !skip_pending_reg;
  wire        is_table_op  = (op_code_i == table_read_current_page_op) ||
                             (op_code_i == table_read_last_page_op) ||
                             (op_code_i == preinc_table_read_op) ||
                             (op_code_i == preinc_table_read_last_page_op);
  wire        is_preinc    = (op_code_i == preinc_table_read_op) ||
                             (op_code_i == preinc_table_read_last_page_op);
  wire        is_last_page = (op_code_i == table_read_last_page_op) ||
                             (op_code_i == preinc_table_read_last_page_op);
  wire [7:0]  ptr_low_used = is_preinc ? 8'(table_pointer_low + 8'h01)
                                       : table_pointer_low;
  wire [PM_AW-9:0] last_page = '1;
  wire [PM_AW-9:0] page_used =
      is_last_page                           ? last_page :
      (op_code_i == preinc_table_read_op)    ? table_pointer_high :
                                               cur_page_i;
  wire [PM_AW-1:0] pm_addr_next = {page_used, ptr_low_used};

  wire [7:0]  xor_res      = acc_o ^ dm_rdata_i;
  wire        xor_zero     = (xor_res == 8'h00);
  wire        in_dm_data   = (state_reg == st_dm_data);
  wire        skip_taken   = in_dm_data &&
      (((op_reg == copy_test_skip_op) && (dm_rdata_i == 8'h00)) ||
       ((op_reg == test_skip_op) && !dm_rdata_i[bit_reg]));
  wire        xor_acc_now  = in_dm_data && (op_reg == xor_to_accumulator_op);
  wire        xor_mem_now  = in_dm_data && (op_reg == xor_to_memory_op);
  wire        copy_now     = in_dm_data && (op_reg == copy_test_skip_op);
  wire        pm_data_now  = (state_reg == st_pm_data);
  wire [7:0]  status_rd    = {5'h00, (state_reg != st_idle), skip_pending_reg, zero_o};

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      st_idle: begin
        if (accept_skip) begin
          state_next = st_dummy;
        end else if (accept_exec && is_table_op) begin
          state_next = st_pm_req;
        end else if (accept_exec) begin
          state_next = st_dm_req;
        end
      end
      st_dm_req:  state_next = st_dm_data;
      st_dm_data: state_next = xor_mem_now ? st_write : st_idle;
      st_pm_req:  state_next = st_pm_data;
      st_pm_data: state_next = st_write;
      st_write:   state_next = st_idle;
      st_dummy:   state_next = st_idle;
      default:    state_next = st_idle;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg  <= st_idle;
      op_reg     <= copy_test_skip_op;
      bit_reg    <= 3'h0;
      op_ready_o <= 1'b0;
    end else begin
      state_reg  <= state_next;
      op_reg     <= accept ? op_code_i : op_reg;
      bit_reg    <= accept ? op_bit_i : bit_reg;
      op_ready_o <= (state_next == st_idle);
    end
  end

  // ---------------------------------------------------------------
  // Skip and dummy cycle
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      skip_pending_reg <= 1'b0;
      skip_o           <= 1'b0;
      dummy_o          <= 1'b0;
    end else begin
      if (skip_taken) begin
        skip_pending_reg <= 1'b1;
      end else if (accept_skip) begin
        skip_pending_reg <= 1'b0;
      end
      skip_o  <= skip_taken;
      dummy_o <= accept_skip;
    end
  end

  // ---------------------------------------------------------------
  // Memory ports
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dm_addr_o  <= '0;
      dm_rd_o    <= 1'b0;
      dm_wr_o    <= 1'b0;
      dm_wdata_o <= `RST_BYTE;
      pm_addr_o  <= '0;
      pm_rd_o    <= 1'b0;
    end else begin
      dm_addr_o <= accept_exec ? op_addr_i : dm_addr_o;
      dm_rd_o   <= accept_exec && !is_table_op;
      pm_addr_o <= (accept_exec && is_table_op) ? pm_addr_next : pm_addr_o;
      pm_rd_o   <= accept_exec && is_table_op;
      dm_wr_o   <= (state_next == st_write);
      if (xor_mem_now) begin
        dm_wdata_o <= xor_res;
      end else if (pm_data_now) begin
        dm_wdata_o <= pm_rdata_i[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Accumulator, zero flag, pointers, latch
  // ---------------------------------------------------------------
  // Execution wins over a software write landing on the same edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_o              <= `RST_BYTE;
      zero_o             <= `RST_ZERO_FLAG;
      table_pointer_low  <= `RST_BYTE;
      table_pointer_high <= '0;
      table_high_latch_o <= `RST_BYTE;
    end else begin
      if (xor_acc_now) begin
        acc_o <= xor_res;
      end else if (copy_now) begin
        acc_o <= dm_rdata_i;
      end else if (wr_accum) begin
        acc_o <= wb_dat_i[7:0];
      end
      if (xor_acc_now || xor_mem_now) begin
        zero_o <= xor_zero;
      end else if (wr_status) begin
        zero_o <= wb_dat_i[`ST_ZERO_BIT];
      end
      if (accept_exec && is_table_op && is_preinc) begin
        table_pointer_low <= ptr_low_used;
      end else if (wr_ptr_low) begin
        table_pointer_low <= wb_dat_i[7:0];
      end
      if (wr_ptr_high) begin
        table_pointer_high <= wb_dat_i[PM_AW-9:0];
      end
      if (pm_data_now) begin
        table_high_latch_o <= pm_rdata_i[15:8];
      end
    end
  end

  // ---------------------------------------------------------------
  // Register access
  // ---------------------------------------------------------------
  wb_reg_slave u_regs (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .wb_cyc_i      (wb_cyc_i),
    .wb_stb_i      (wb_stb_i),
    .wb_we_i       (wb_we_i),
    .wb_adr_i      (wb_adr_i),
    .wb_sel_i      (wb_sel_i),
    .wb_dat_o      (wb_dat_o),
    .wb_ack_o      (wb_ack_o),
    .rd_accum_i    (acc_o),
    .rd_ptr_low_i  (table_pointer_low),
    .rd_ptr_high_i (8'(table_pointer_high)),
    .rd_tbl_high_i (table_high_latch_o),
    .rd_status_i   (status_rd),
    .wr_accum_o    (wr_accum),
    .wr_ptr_low_o  (wr_ptr_low),
    .wr_ptr_high_o (wr_ptr_high),
    .wr_status_o   (wr_status)
  );

endmodule

// ===== testbench/skip_exec_checker.sv
// Purpose: Port-level checks of the skip, table read and XOR block
// Assumes: Memories answer one cycle after their read strobe
// Notes:   Bound to the top module; sees its ports only
`timescale 1ns/100ps

module skip_exec_checker
  import skip_table_pkg::*;
#(
  parameter int DM_AW = 9,
  parameter int PM_AW = 16
) (
  // Clock and reset
  input wire logic             clk_i,
  input wire logic             rst_i,
  // Instruction port
  input wire logic             op_valid_i,
  input wire op_code_t         op_code_i,
  input wire logic [2:0]       op_bit_i,
  input wire logic [PM_AW-9:0] cur_page_i,
  input wire logic             op_ready_o,
  input wire logic             skip_o,
  input wire logic             dummy_o,
  // Memories
  input wire logic             dm_rd_o,
  input wire logic             dm_wr_o,
  input wire logic [7:0]       dm_wdata_o,
  input wire logic [7:0]       dm_rdata_i,
  input wire logic [PM_AW-1:0] pm_addr_o,
  input wire logic             pm_rd_o,
  input wire logic [15:0]      pm_rdata_i,
  // Core state and bus
  input wire logic [7:0]       acc_o,
  input wire logic             zero_o,
  input wire logic [7:0]       table_high_latch_o,
  input wire logic             wb_ack_o
);
  // ----
  // Helpers
  // ----
  logic       pend_reg;
  logic [7:0] d_reg;
  logic [15:0] w_reg;
  logic [2:0] bit_reg;
  wire take = op_valid_i && op_ready_o;
  // Skip may be granted in the very cycle the next op is taken
  wire sup = skip_o || pend_reg;
  wire go = take && !sup;
  wire tbl = op_code_i >= table_read_current_page_op && op_code_i <= 3'h5;
  wire last = op_code_i == table_read_last_page_op || op_code_i == 3'h5;

  always_ff @(posedge clk_i) begin
    pend_reg <= rst_i ? 1'b0 : take ? 1'b0 : skip_o ? 1'b1 : pend_reg;
    d_reg <= dm_rdata_i;
    w_reg <= pm_rdata_i;
    bit_reg <= take ? op_bit_i : bit_reg;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_COPY: assert property (go && op_code_i == copy_test_skip_op |->
    ##1 dm_rd_o ##2 acc_o == d_reg && skip_o == (d_reg == 8'h00)) else $error("copy result");
  AST_BIT: assert property (go && op_code_i == test_skip_op |->
    ##3 skip_o == !d_reg[bit_reg]) else $error("bit test skip");
  AST_DUMMY: assert property (take && sup |=> dummy_o && !op_ready_o ##1 op_ready_o)
    else $error("dummy cycle");
  AST_QUIET: assert property (dummy_o |-> !dm_wr_o && !pm_rd_o && $stable(acc_o)
    ##1 !dm_wr_o && $stable(acc_o) && $stable(zero_o) && $stable(table_high_latch_o))
    else $error("suppressed op changed state");
  AST_TBL: assert property (go && tbl |-> ##1 pm_rd_o ##2 dm_wr_o &&
    dm_wdata_o == w_reg[7:0] && table_high_latch_o == w_reg[15:8]) else $error("table data");
  AST_LASTPG: assert property (go && last |=> pm_addr_o[PM_AW-1:8] == '1)
    else $error("last page address");
  AST_CURPG: assert property (go && op_code_i == table_read_current_page_op |=>
    pm_addr_o[PM_AW-1:8] == cur_page_i) else $error("current page address");
  AST_XACC: assert property (go && op_code_i == xor_to_accumulator_op |-> ##3
    acc_o == ($past(acc_o, 3) ^ d_reg) && zero_o == (acc_o == 8'h00)) else $error("xor acc");
  AST_XMEM: assert property (go && op_code_i == xor_to_memory_op |-> ##3 dm_wr_o &&
    dm_wdata_o == ($past(acc_o, 3) ^ d_reg) && acc_o == $past(acc_o, 3) &&
    zero_o == (dm_wdata_o == 8'h00)) else $error("xor mem");
  AST_ACK: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
endmodule

bind skip_table_read_xor_exec skip_exec_checker #(.DM_AW(DM_AW), .PM_AW(PM_AW))
  skip_exec_checker_i (
    .clk_i              (clk_i),
    .rst_i              (rst_i),
    .op_valid_i         (op_valid_i),
    .op_code_i          (op_code_i),
    .op_bit_i           (op_bit_i),
    .cur_page_i         (cur_page_i),
    .op_ready_o         (op_ready_o),
    .skip_o             (skip_o),
    .dummy_o            (dummy_o),
    .dm_rd_o            (dm_rd_o),
    .dm_wr_o            (dm_wr_o),
    .dm_wdata_o         (dm_wdata_o),
    .dm_rdata_i         (dm_rdata_i),
    .pm_addr_o          (pm_addr_o),
    .pm_rd_o            (pm_rd_o),
    .pm_rdata_i         (pm_rdata_i),
    .acc_o              (acc_o),
    .zero_o             (zero_o),
    .table_high_latch_o (table_high_latch_o),
    .wb_ack_o           (wb_ack_o)
  );

// ===== testbench/mem_model.sv
// Purpose: Data and program memory beside the execution block
// Assumes: Read data is valid only in the cycle after the strobe
// Notes:   Program word is its address XOR a fixed pattern
`timescale 1ns/100ps

module mem_model (
  // Clock
  input  wire logic        clk_i,
  // Data memory
  input  wire logic [8:0]  dm_addr_i,
  input  wire logic        dm_rd_i,
  input  wire logic        dm_wr_i,
  input  wire logic [7:0]  dm_wdata_i,
  output logic      [7:0]  dm_rdata_o,
  // Program memory
  input  wire logic [15:0] pm_addr_i,
  input  wire logic        pm_rd_i,
  output logic      [15:0] pm_rdata_o
);
  logic [7:0] dm [512];
  initial begin
    dm_rdata_o = 8'h00;
    pm_rdata_o = 16'h0000;
  end
  // Stale data inverts each cycle so a late sample is caught
  always @(posedge clk_i) begin
    if (dm_wr_i === 1'b1) dm[dm_addr_i] <= dm_wdata_i;
    dm_rdata_o <= (dm_rd_i === 1'b1) ? dm[dm_addr_i] : ~dm_rdata_o;
    pm_rdata_o <= (pm_rd_i === 1'b1) ? (pm_addr_i ^ 16'hc33c) : ~pm_rdata_o;
  end
endmodule

// ===== testbench/skip_table_read_xor_exec_tb.sv
// Purpose: Directed test of the skip, table read and XOR block
// Assumes: Classic Wishbone, memory model answering one cycle late
// Notes:   Expected values follow from the memory contents set here
`timescale 1ns/100ps
`include "skip_table_cfg.svh"
`define chk(a, e, m) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("mismatch at %0t: %s", $time, m); end end

module skip_table_read_xor_exec_tb
  import skip_table_pkg::*;
;
  logic        clk_i, rst_i, op_valid_i, op_ready_o, skip_o, dummy_o, zero_o;
  logic        dm_rd_o, dm_wr_o, pm_rd_o, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  op_code_t    op_code_i;
  logic [8:0]  op_addr_i, dm_addr_o;
  logic [2:0]  op_bit_i;
  logic [7:0]  cur_page_i, dm_wdata_o, dm_rdata_i, acc_o, table_high_latch_o, wb_adr_i, lo;
  logic [15:0] pm_addr_o, pm_rdata_i, pm_seen, ea;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  int          n_mismatch = 0, n_checks = 0, n_cyc = 0, n_skip = 0, n_dummy = 0;

  skip_table_read_xor_exec skip_table_read_xor_exec_i (.clk_i, .rst_i, .op_valid_i,
    .op_code_i, .op_addr_i, .op_bit_i, .cur_page_i, .op_ready_o, .skip_o, .dummy_o,
    .dm_addr_o, .dm_rd_o, .dm_wr_o, .dm_wdata_o, .dm_rdata_i, .pm_addr_o, .pm_rd_o,
    .pm_rdata_i, .acc_o, .zero_o, .table_high_latch_o, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
  mem_model mem_model_i (.clk_i, .dm_addr_i(dm_addr_o), .dm_rd_i(dm_rd_o),
    .dm_wr_i(dm_wr_o), .dm_wdata_i(dm_wdata_o), .dm_rdata_o(dm_rdata_i),
    .pm_addr_i(pm_addr_o), .pm_rd_i(pm_rd_o), .pm_rdata_o(pm_rdata_i));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // ----
  // Monitors and timeout
  // ----
  always @(posedge clk_i) begin
    n_cyc++;
    if (skip_o === 1'b1) n_skip++;
    if (dummy_o === 1'b1) n_dummy++;
    if (pm_rd_o === 1'b1) pm_seen = pm_addr_o;
    if (n_cyc == 3000) begin
      n_mismatch++;
      results();
    end
  end

  task results;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= 4'h1;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // Offer one op, hold it until taken, then wait until idle again
  task run(input op_code_t c, input logic [8:0] a, input logic [2:0] b);
    @(posedge clk_i);
    op_valid_i <= 1'b1;
    op_code_i <= c;
    op_addr_i <= a;
    op_bit_i <= b;
    do @(posedge clk_i); while (op_ready_o !== 1'b1);
    op_valid_i <= 1'b0;
    do @(posedge clk_i); while (op_ready_o !== 1'b1);
    @(negedge clk_i);
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    rst_i = 1'b1;
    op_valid_i = 1'b0;
    op_code_i = copy_test_skip_op;
    op_addr_i = 9'h000;
    op_bit_i = 3'h0;
    cur_page_i = 8'h34;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h1;
    wb_dat_i = 32'h00000000;
    mem_model_i.dm[3] = 8'h00;
    mem_model_i.dm[4] = 8'h80;
    mem_model_i.dm[6] = 8'h3c;
    mem_model_i.dm[7] = 8'h66;
    mem_model_i.dm[9] = 8'h11;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, 8'(i * 4), 8'h00);
      `chk(rd, 32'h00000000, "reset value or unmapped read")
    end
    wb(1'b1, `OFS_ACCUM, 8'h5a);
    wb(1'b1, `OFS_TBL_PTR_LOW, 8'hfe);
    wb(1'b1, `OFS_TBL_PTR_HIGH, 8'h12);
    wb(1'b1, `OFS_TBL_HIGH, 8'h77);
    wb(1'b0, `OFS_TBL_HIGH, 8'h00);
    `chk(rd, 32'h00000000, "latch is read only")
    wb(1'b0, `OFS_ACCUM, 8'h00);
    `chk(rd, 32'h0000005a, "accumulator read back")
    wb(1'b0, `OFS_TBL_PTR_HIGH, 8'h00);
    `chk(rd, 32'h00000012, "pointer high read back")
    run(xor_to_accumulator_op, 9'h006, 3'h0);
    `chk({zero_o, acc_o}, 9'h066, "xor to acc")
    run(xor_to_memory_op, 9'h007, 3'h0);
    `chk({zero_o, acc_o, mem_model_i.dm[7]}, 17'h16600, "xor to mem")
    wb(1'b0, `OFS_STATUS, 8'h00);
    `chk(rd, 32'h00000001, "zero flag in status")
    run(copy_test_skip_op, 9'h004, 3'h0);
    `chk({zero_o, acc_o}, 9'h180, "copy nonzero")
    run(test_skip_op, 9'h004, 3'h7);
    `chk(n_skip, 0, "bit set no skip")
    run(test_skip_op, 9'h004, 3'h6);
    `chk(n_skip, 1, "bit clear skip")
    wb(1'b0, `OFS_STATUS, 8'h00);
    `chk(rd, 32'h00000003, "skip pending in status")
    run(xor_to_accumulator_op, 9'h006, 3'h0);
    `chk({n_dummy, zero_o, acc_o}, {32'd1, 1'b1, 8'h80}, "suppressed xor")
    run(copy_test_skip_op, 9'h003, 3'h0);
    `chk({n_skip, acc_o}, {32'd2, 8'h00}, "copy zero skip")
    run(table_read_current_page_op, 9'h009, 3'h0);
    `chk({table_high_latch_o, mem_model_i.dm[9]}, 16'h0011, "suppressed read")
    `chk(n_dummy, 2, "second dummy")
    lo = 8'hfe;
    for (int i = 2; i < 6; i++) begin
      if (i >= 4) lo = lo + 8'h01;
      ea = {(i == 2) ? 8'h34 : (i == 4) ? 8'h12 : 8'hff, lo};
      run(op_code_t'(i), 9'(16 + i), 3'h0);
      `chk(pm_seen, ea, "table address")
      `chk(mem_model_i.dm[16 + i], ea[7:0] ^ 8'h3c, "table low")
      `chk(table_high_latch_o, ea[15:8] ^ 8'hc3, "table high")
    end
    wb(1'b0, `OFS_TBL_PTR_LOW, 8'h00);
    `chk(rd, 32'h00000000, "pointer wrap")
    wb(1'b0, `OFS_TBL_HIGH, 8'h00);
    `chk(rd, 32'h0000003c, "latch read back")
    results();
  end
endmodule
